/* etd_tx_dma.v */
// Transmit descriptor DMA engine with APB registers and checksum insertion
// Overview of operation
// - Word0 bit 31 set means engine owns descriptor; clear means host owns.
// - Engine clears ownership after the buffer is consumed, before the frame is sent.
// - Word1 bit 31 on last segment raises transmit interrupt after frame.
// - Word1 bit 30 marks first segment; a new frame starts there.
// - Word1 bit 29 marks last segment; frame ends after its data.
// - Bit 28 inserts IP header checksum, 20-byte header only.
// - Per-descriptor checksum bits apply only when global bit is clear.
// - Bit 27 inserts TCP checksum, IP header 20 bytes.
// - Bit 26 inserts UDP checksum, IP header 20 bytes.
// - End-of-ring bit 25 makes engine return to list base.
// - Word1 bits 10:0 give buffer length; zero length is skipped.
// - Word2 is buffer address; any byte alignment accepted.
// - Word3 is word-aligned next descriptor address, followed by engine.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "etd_defs.vh"
module etd_tx_dma #(
    parameter AW = 11
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Memory master, word reads and writes
    output reg         mem_req,
    output reg         mem_we,
    output reg  [31:0] mem_addr,
    output reg  [31:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata,
    // Frame byte stream to MAC
    output reg  [7:0]  tx_data,
    output reg         tx_valid,
    output reg         tx_last,
    input  wire        tx_ready,
    // Interrupt
    output wire        irq
);
    localparam S_IDLE = 4'h0, S_D0 = 4'h1, S_D1 = 4'h2, S_D2 = 4'h3, S_D3 = 4'h4;
    localparam S_RD = 4'h5, S_WB = 4'h6, S_NEXT = 4'h7, S_PATCH = 4'h8;
    localparam S_SEND = 4'h9, S_SUSP = 4'hA;

    reg  [3:0]    state;
    reg  [31:0]   ctrl, base, stat, mask, cur, w0, w1, w2, w3;
    reg  [10:0]   left;
    reg  [31:0]   baddr;
    reg  [AW-1:0] wptr, rptr;
    reg           in_frame, do_ip, do_l4, do_udp, fin, fire;
    reg  [16:0]   ipsum;
    reg  [31:0]   l4sum;
    reg  [7:0]    proto, ihl;
    reg  [2:0]    patch;
    reg           poll;
    reg           ram_we;
    reg  [AW-1:0] ram_wa;
    reg  [7:0]    ram_wd;
    wire [7:0]    ram_rd;
    reg           rd_ok;

    // ctrl: [0] enable, [1] global IP, [2] global TCP, [3] global UDP, [4] stored, no effect
    wire en       = ctrl[0];
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire [1:0] bl = baddr[1:0];
    wire [7:0] byte_in = mem_rdata[8*bl +: 8];
    // Read address holds the pending byte while the sink stalls
    wire          rd_adv  = (state == S_SEND) && (!tx_valid || tx_ready) && (rptr != wptr + 1'b1);
    wire [AW-1:0] rd_addr = rd_adv ? rptr : rptr - 1'b1;

    function [15:0] fold;
        input [31:0] s;
        reg   [31:0] t;
        begin
            t    = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
            t    = {16'h0000, t[15:0]} + {16'h0000, t[31:16]};
            fold = ~t[15:0];
        end
    endfunction

    // Byte placed in its half of a 16-bit checksum word
    function [31:0] sum_lane;
        input [7:0] b;
        input       odd;
        begin
            sum_lane = odd ? {24'h0, b} : {16'h0, b, 8'h00};
        end
    endfunction

    wire [15:0] ip_ck = fold({15'h0, ipsum});
    wire [15:0] l4_ck = fold(l4sum + {24'h0, proto} + {21'h0, wptr - 11'd34});

    etd_sum_ram #(.AW(AW), .DW(8)) u_ram (
        .pclk  (pclk),
        .we    (ram_we),
        .waddr (ram_wa),
        .wdata (ram_wd),
        .raddr (rd_addr),
        .rdata (ram_rd)
    );

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irq     = |(stat & mask);

    always @* begin
        case (paddr)
            `ETD_REG_CTRL: prdata = ctrl;
            `ETD_REG_BASE: prdata = base;
            `ETD_REG_STAT: prdata = stat;
            `ETD_REG_MASK: prdata = mask;
            `ETD_REG_CUR:  prdata = cur;
            default:       prdata = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `ETD_CTRL_RST;
            base <= 32'h00000000;
            mask <= 32'h00000000;
            stat <= 32'h00000000;
            poll <= 1'b0;
        end else begin
            poll <= wr && paddr == `ETD_REG_POLL;
            if (wr && paddr == `ETD_REG_CTRL) ctrl <= {27'h0, pwdata[4:0]};
            if (wr && paddr == `ETD_REG_BASE) base <= {pwdata[31:2], 2'b00};
            if (wr && paddr == `ETD_REG_MASK) mask <= {29'h0, pwdata[2:0]};
            // Set wins over write-one-to-clear
            stat <= (stat & ~((wr && paddr == `ETD_REG_STAT) ? pwdata : 32'h0))
                  | {29'h0, 1'b0, state == S_SUSP, fire};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= S_IDLE;
            cur       <= 32'h0;
            w0        <= 32'h0;
            w1        <= 32'h0;
            w2        <= 32'h0;
            w3        <= 32'h0;
            left      <= 11'h0;
            baddr     <= 32'h0;
            wptr      <= {AW{1'b0}};
            rptr      <= {AW{1'b0}};
            in_frame  <= 1'b0;
            do_ip     <= 1'b0;
            do_l4     <= 1'b0;
            do_udp    <= 1'b0;
            fin       <= 1'b0;
            fire      <= 1'b0;
            ipsum     <= 17'h0;
            l4sum     <= 32'h0;
            proto     <= 8'h0;
            ihl       <= 8'h0;
            patch     <= 3'h0;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 32'h0;
            mem_wdata <= 32'h0;
            tx_data   <= 8'h0;
            tx_valid  <= 1'b0;
            tx_last   <= 1'b0;
            ram_we    <= 1'b0;
            ram_wa    <= {AW{1'b0}};
            ram_wd    <= 8'h0;
            rd_ok     <= 1'b0;
        end else begin
            fire   <= 1'b0;
            ram_we <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (en) begin
                        cur <= base; mem_addr <= base; mem_req <= 1'b1; state <= S_D0;
                    end
                end
                S_D0, S_D1, S_D2, S_D3: begin
                    if (mem_ack) begin
                        mem_addr <= mem_addr + 32'h4;
                        case (state)
                            S_D0: begin
                                w0 <= mem_rdata;
                                if (!mem_rdata[`ETD_OWN_BIT]) begin
                                    mem_req <= 1'b0; state <= S_SUSP;
                                end else state <= S_D1;
                            end
                            S_D1: begin w1 <= mem_rdata; state <= S_D2; end
                            S_D2: begin
                                w2 <= mem_rdata; baddr <= mem_rdata;
                                state <= S_D3;
                            end
                            default: begin
                                w3 <= mem_rdata; mem_req <= 1'b0;
                                left <= w1[`ETD_LEN_HI:0];
                                if (w1[`ETD_FS_BIT]) begin
                                    in_frame <= 1'b1; wptr <= {AW{1'b0}};
                                    ipsum <= 17'h0; l4sum <= 32'h0;
                                    do_ip  <= ctrl[1] | w1[`ETD_IPG_BIT];
                                    do_l4  <= ctrl[2] | w1[`ETD_TCPG_BIT];
                                    do_udp <= ctrl[3] | w1[`ETD_UDPG_BIT];
                                    ihl    <= 8'h00;
                                    proto  <= 8'h00;
                                end
                                state <= S_RD;
                            end
                        endcase
                    end
                end
                S_RD: begin
                    if (left == 11'h0 || !in_frame) begin
                        fin <= w1[`ETD_LS_BIT] & in_frame;
                        mem_addr <= cur; mem_we <= 1'b1; mem_req <= 1'b1;
                        mem_wdata <= w0 & ~(32'h1 << `ETD_OWN_BIT);
                        state <= S_WB;
                    end else if (!mem_req) begin
                        mem_addr <= {baddr[31:2], 2'b00}; mem_req <= 1'b1;
                    end else if (mem_ack) begin
                        mem_req <= 1'b0; baddr <= baddr + 32'h1;
                        left <= left - 11'h1; ram_we <= 1'b1;
                        ram_wa <= wptr; ram_wd <= byte_in; wptr <= wptr + 1'b1;
                        if (wptr == 11'd23) proto <= byte_in;
                        if (wptr == 11'd14) ihl <= byte_in;
                        if (wptr >= 11'd14 && wptr < 11'd34 && wptr != 11'd24 && wptr != 11'd25)
                            ipsum <= {1'b0, ~fold({15'h0, ipsum} + sum_lane(byte_in, wptr[0]))};
                        if (wptr >= 11'd26
                            && !(proto == 8'h06 && (wptr == 11'd50 || wptr == 11'd51))
                            && !(proto == 8'h11 && (wptr == 11'd40 || wptr == 11'd41)))
                            l4sum <= l4sum + sum_lane(byte_in, wptr[0]);
                    end
                end
                S_WB: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0; mem_we <= 1'b0;
                        state <= (fin) ? S_PATCH : S_NEXT;
                        patch <= 3'h0;
                    end
                end
                S_PATCH: begin
                    // Overwrite checksum fields, 20-byte IP header only
                    patch <= patch + 3'h1;
                    ram_we <= 1'b1;
                    case (patch)
                        3'h0: begin ram_wa <= 11'd24;
                            ram_wd <= ip_ck[15:8]; end
                        3'h1: begin ram_wa <= 11'd25;
                            ram_wd <= ip_ck[7:0]; end
                        3'h2: begin ram_wa <= (proto == 8'h11) ? 11'd40 : 11'd50;
                            ram_wd <= l4_ck[15:8]; end
                        3'h3: begin ram_wa <= (proto == 8'h11) ? 11'd41 : 11'd51;
                            ram_wd <= l4_ck[7:0]; end
                        default: begin
                            ram_we <= 1'b0; rptr <= {AW{1'b0}}; rd_ok <= 1'b0; state <= S_SEND;
                        end
                    endcase
                    if ((patch == 3'h2 || patch == 3'h3) &&
                        !(ihl == 8'h45 && ((do_l4 && proto == 8'h06) || (do_udp && proto == 8'h11))))
                        ram_we <= 1'b0;
                    if ((patch == 3'h0 || patch == 3'h1) && !(do_ip && ihl == 8'h45))
                        ram_we <= 1'b0;
                end
                S_SEND: begin
                    if (!tx_valid || tx_ready) begin
                        if (rd_ok && rptr != wptr + 1'b1) begin
                            tx_valid <= 1'b1; tx_data <= ram_rd;
                            tx_last <= (rptr == wptr);
                        end else tx_valid <= 1'b0;
                        if (rptr == wptr + 1'b1 && tx_valid && tx_last) begin
                            tx_valid <= 1'b0; tx_last <= 1'b0; in_frame <= 1'b0;
                            fire <= w1[`ETD_IC_BIT];
                            state <= S_NEXT;
                        end else if (rptr != wptr + 1'b1) begin
                            rptr <= rptr + 1'b1; rd_ok <= 1'b1;
                        end
                    end
                end
                S_NEXT: begin
                    cur <= w1[`ETD_TER_BIT] ? base : {w3[31:2], 2'b00};
                    mem_addr <= w1[`ETD_TER_BIT] ? base : {w3[31:2], 2'b00};
                    mem_req <= en; state <= en ? S_D0 : S_IDLE;
                end
                S_SUSP: begin
                    if (poll && en) begin
                        mem_addr <= cur; mem_req <= 1'b1; state <= S_D0;
                    end else if (!en) state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

/* etd_defs.vh */
// Constants of the transmit descriptor engine
`ifndef ETD_DEFS_VH
`define ETD_DEFS_VH
`define ETD_OWN_BIT      31
`define ETD_IC_BIT       31
`define ETD_FS_BIT       30
`define ETD_LS_BIT       29
`define ETD_IPG_BIT      28
`define ETD_TCPG_BIT     27
`define ETD_UDPG_BIT     26
`define ETD_TER_BIT      25
`define ETD_LEN_HI       10
`define ETD_REG_CTRL     12'h000
`define ETD_REG_BASE     12'h004
`define ETD_REG_STAT     12'h008
`define ETD_REG_MASK     12'h00C
`define ETD_REG_CUR      12'h010
`define ETD_REG_POLL     12'h014
`define ETD_CTRL_RST     32'h00000000
`define ETD_ST_TXDONE    0
`define ETD_ST_SUSP      1
`define ETD_ST_ERR       2
`define ETD_IPH_BYTES    20
`endif

/* etd_sum_ram.v */
// Small frame store with registered read data
`timescale 1ns/1ps
module etd_sum_ram #(
    parameter AW = 11,
    parameter DW = 8
) (
    // Clock
    input  wire          pclk,
    // Write port
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    // Read port
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

/* etd_tx_dma_monitor.sv */
// Port checker for the transmit descriptor engine
`timescale 1ns/1ps
`include "etd_defs.vh"
module etd_tx_dma_monitor #(
    parameter AW = 11
) (
    // Clock and reset
    input logic        pclk,
    input logic        presetn,
    // APB
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // Memory and stream
    input logic        mem_req,
    input logic        mem_we,
    input logic [31:0] mem_addr,
    input logic [31:0] mem_wdata,
    input logic        mem_ack,
    input logic [7:0]  tx_data,
    input logic        tx_valid,
    input logic        tx_last,
    input logic        tx_ready,
    // Interrupt
    input logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_apb_ok; psel |-> pready && !pslverr; endproperty
    a_apb_ok: assert property (p_apb_ok) else $error("APB not ready");
    property p_rst_quiet; $rose(presetn) |-> !mem_req && !tx_valid && !irq; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("Output active after reset");
    property p_mem_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("Memory request dropped");
    property p_own_wb; mem_req && mem_we |-> mem_addr[1:0] == 2'h0 && !mem_wdata[31]; endproperty
    a_own_wb: assert property (p_own_wb) else $error("Bad ownership writeback");
    property p_rd_word; mem_req && !mem_we |-> mem_addr[1:0] == 2'h0; endproperty
    a_rd_word: assert property (p_rd_word) else $error("Unaligned word read");
    property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("Stream byte changed in stall");
    property p_mask_off;
        psel && penable && pwrite && paddr == `ETD_REG_MASK && pwdata == 32'h0 |=> !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("Interrupt while masked");
    property p_bad_rd; psel && penable && !pwrite && paddr == 12'h0FC |-> prdata == 32'h0;
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("Unmapped read not zero");
    c_frame: cover property (tx_valid && tx_ready && tx_last);
    c_irq: cover property ($rose(irq));
    c_wb: cover property (mem_req && mem_we && mem_ack);
endmodule
bind etd_tx_dma etd_tx_dma_monitor #(.AW(AW)) u_mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .tx_data, .tx_valid, .tx_last, .tx_ready, .irq);

/* etd_mem_model.sv */
// Shared memory model holding descriptors and buffers
`timescale 1ns/1ps
module etd_mem_model (
    // Clock and reset
    input  logic        pclk,
    input  logic        presetn,
    // Word access port
    input  logic        mem_req,
    input  logic        mem_we,
    input  logic [31:0] mem_addr,
    input  logic [31:0] mem_wdata,
    output logic        mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:255];
    logic [1:0]  wcnt;
    logic        slow;
    wire  [7:0]  idx = mem_addr[9:2];
    // Alternates prompt and slow answers; data scrambled when idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            wcnt      <= 2'h0;
            slow      <= 1'b0;
            mem_rdata <= 32'h5A5A5A5A;
        end else if (mem_ack || !mem_req) begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            slow      <= slow ^ mem_ack;
        end else if (slow && wcnt != 2'h3) begin
            wcnt <= wcnt + 2'h1;
        end else begin
            wcnt    <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_we)
                mem[idx] <= mem_wdata;
            else
                mem_rdata <= mem[idx];
        end
    end
endmodule

/* etd_tx_dma_tb_top.sv */
// Self-checking bench for the transmit descriptor engine
`timescale 1ns/1ps
`include "etd_defs.vh"
module etd_tx_dma_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic        tx_ready = 1'b0;
    wire  [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
    wire  [7:0]  tx_data;
    wire         pready, pslverr, mem_req, mem_we, mem_ack, tx_valid, tx_last, irq;
    logic [7:0]  got_q[$];
    logic [11:0] ra [4];
    logic [31:0] rw [4], re [4];
    int          miscompares = 0, cmp_count = 0;
    always #12.5 pclk = ~pclk;
    etd_tx_dma #(.AW(11)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata, .tx_data, .tx_valid, .tx_last, .tx_ready, .irq);
    etd_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_irq(input logic e);
        @(negedge pclk);
        chk(32'(irq), 32'(e));
    endtask
    task close_out;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Stalling sink; last flag expected at each frame end
    always @(posedge pclk) begin
        tx_ready <= ~tx_ready;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got_q.push_back(tx_data);
            chk(32'(tx_last), 32'(got_q.size() inside {3, 6, 40}));
        end
    end
    initial begin
        #500000;
        miscompares++;
        close_out();
    end
    initial begin
        int n;
        ra = '{`ETD_REG_CTRL, `ETD_REG_BASE, `ETD_REG_MASK, 12'h0FC};
        rw = '{32'h10, 32'h100, 32'h1, 32'hFFFFFFFF};
        re = '{32'h10, 32'h100, 32'h1, 32'h0};
        // Two-descriptor ring, first owner bit set last
        u_mem.mem[68] = 32'h80000000;
        u_mem.mem[69] = 32'h02000000;
        u_mem.mem[70] = 32'h0;
        u_mem.mem[71] = 32'h120;
        u_mem.mem[65] = 32'hE0000003;
        u_mem.mem[66] = 32'h203;
        u_mem.mem[67] = 32'h110;
        u_mem.mem[128] = 32'hA1000000;
        u_mem.mem[129] = 32'h0000B3B2;
        u_mem.mem[64] = 32'h80000000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({mem_req, tx_valid, irq}), 32'h0);
        apb(0, `ETD_REG_STAT, 0);
        chk(rd, 32'h0);
        apb(0, `ETD_REG_CTRL, 0);
        chk(rd, `ETD_CTRL_RST);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            apb(1, ra[i], rw[i]);
            apb(0, ra[i], 0);
            chk(rd, re[i]);
        end
        $display("Test registers done");
        apb(1, `ETD_REG_CTRL, 32'h11);
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge pclk);
        chk(32'(irq), 32'h1);
        chk(32'(got_q.size()), 32'h3);
        chk(32'({got_q[0], got_q[1], got_q[2]}), 32'hA1B2B3);
        chk(32'(u_mem.mem[64][31]), 32'h0);
        n = 0;
        do begin
            apb(0, `ETD_REG_STAT, 0);
            n++;
        end while (rd[1] !== 1'b1 && n < 100);
        chk(32'(rd[2:0]), 32'h3);
        chk(32'(got_q.size()), 32'h3);
        apb(0, `ETD_REG_CUR, 0);
        chk(rd, 32'h100);
        $display("Test ring done");
        apb(1, `ETD_REG_MASK, 0);
        chk_irq(0);
        apb(1, `ETD_REG_MASK, 1);
        chk_irq(1);
        apb(1, `ETD_REG_STAT, 1);
        chk_irq(0);
        $display("Test interrupt done");
        u_mem.mem[64] = 32'h80000000;
        apb(1, `ETD_REG_POLL, 1);
        for (n = 0; n < 3000 && got_q.size() < 6; n++) @(posedge pclk);
        chk(32'(got_q.size()), 32'h6);
        chk(32'(got_q[3]), 32'hA1);
        $display("Test poll done");
        // Two-segment frame with IP header checksum, first owner bit set last
        repeat (50) @(posedge pclk);
        u_mem.mem[192] = 32'h0;
        u_mem.mem[193] = 32'h0;
        u_mem.mem[194] = 32'h0;
        u_mem.mem[195] = 32'h00450000;
        u_mem.mem[196] = 32'h00001400;
        u_mem.mem[197] = 32'h01400000;
        u_mem.mem[198] = 32'h000AFFFF;
        u_mem.mem[199] = 32'h000A0100;
        u_mem.mem[200] = 32'h00000200;
        u_mem.mem[76] = 32'h80000000;
        u_mem.mem[77] = 32'hBA00000E;
        u_mem.mem[78] = 32'h314;
        u_mem.mem[79] = 32'h100;
        u_mem.mem[69] = 32'h58000014;
        u_mem.mem[70] = 32'h300;
        u_mem.mem[71] = 32'h130;
        u_mem.mem[68] = 32'h80000000;
        apb(1, `ETD_REG_POLL, 1);
        for (n = 0; n < 3000 && got_q.size() < 40; n++) @(posedge pclk);
        chk(32'(got_q.size()), 32'h28);
        chk(32'({got_q[30], got_q[31]}), 32'h66E7);
        chk(32'({got_q[20], got_q[39]}), 32'h4502);
        chk(32'(u_mem.mem[76][31]), 32'h0);
        $display("Test checksum done");
        close_out();
    end
endmodule
